// *** hw/bfcc_top.sv ***
// Purpose: command sequencer, dual-bank array, status and APB registers of a burst NOR flash
// Assumes: host pins are asynchronous and pass bfcc_sync; software uses APB
// Notes: array has no reset, contents start unknown until erased
`timescale 1ns/1ps
`include "bfcc_cfg.svh"
module bfcc_top #(
  parameter logic [31:0] MARK_SEED = 32'h5A3C_0F96 // arbitrary marking value
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire bfcc_pkg::bfcc_pins_t pin_i,
  output logic [`BFCC_DATA_W-1:0] dq_o,
  output logic dq_oe,
  output logic done_indicator,
  output logic irq
);
  localparam int AW = `BFCC_ADDR_W;
  localparam int PW = $bits(bfcc_pkg::bfcc_pins_t);
  localparam logic [15:0] PGM_LAST = 16'(`BFCC_PGM_CYC - 1);
  localparam logic [15:0] SLEEP_LAST = 16'(`BFCC_SLEEP_CYC - 1);

  bfcc_pkg::bfcc_state_t s_ff;
  bfcc_pkg::bfcc_state_t nxt_s;
  bfcc_pkg::bfcc_pins_t pin;
  logic [PW-1:0] pin_raw;

  logic [`BFCC_DATA_W-1:0] mem [0:(1<<AW)-1];
  logic [`BFCC_DATA_W-1:0] mem_q;
  logic [`BFCC_DATA_W-1:0] pgm_old;
  logic mem_we;
  logic [AW-1:0] mem_wa;
  logic [`BFCC_DATA_W-1:0] mem_wd;
  logic [AW-1:0] raddr;

  bfcc_sync #(.W(PW)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(pin_i),
    .q(pin_raw)
  );
  assign pin = bfcc_pkg::bfcc_pins_t'(pin_raw);

  // boot ends hold eight small sectors each, the middle holds big ones
  function automatic logic small_sec(input logic [AW-1:0] a);
    return (a[AW-1:`BFCC_BIG_SEC_W] == '0) || (a[AW-1:`BFCC_BIG_SEC_W] == '1);
  endfunction

  function automatic logic [AW-1:0] sec_base(input logic [AW-1:0] a);
    logic [AW-1:0] m;
    m = small_sec(a) ? AW'((1 << `BFCC_SMALL_SEC_W) - 1) : AW'((1 << `BFCC_BIG_SEC_W) - 1);
    return a & ~m;
  endfunction

  function automatic logic [AW-1:0] sec_last(input logic [AW-1:0] a);
    logic [AW-1:0] m;
    m = small_sec(a) ? AW'((1 << `BFCC_SMALL_SEC_W) - 1) : AW'((1 << `BFCC_BIG_SEC_W) - 1);
    return a | m;
  endfunction

  // top quarter is the small bank
  function automatic logic bank_of(input logic [AW-1:0] a);
    return a[AW-1:AW-2] == 2'b11;
  endfunction

  function automatic logic protected_at(input logic [AW-1:0] a, input logic lock_n,
                                        input logic [31:0] lock);
    logic edge_sec;
    edge_sec = (a[AW-1:`BFCC_SMALL_SEC_W+1] == '0);
    return (~lock_n & edge_sec) | lock[a[AW-1:`BFCC_LOCK_GRP_LSB]];
  endfunction

  function automatic logic [`BFCC_DATA_W-1:0] mark_word(input logic [`BFCC_SECURE_AW-1:0] i);
    return MARK_SEED ^ {4{2'b00, i}};
  endfunction

  function automatic logic [2:0] burst_mask(input logic [1:0] len);
    return (len == 2'h1) ? 3'h1 : (len == 2'h2) ? 3'h3 : 3'h7;
  endfunction

  always_ff @(posedge pclk)
  begin
    if (mem_we)
      mem[mem_wa] <= mem_wd;
    mem_q <= mem[raddr];
    pgm_old <= mem[s_ff.op_addr];
  end

  always_comb
  begin
    logic setup;
    logic access;
    logic we_rise;
    logic oe_fall;
    logic bclk_rise;
    logic busy;
    logic busy_bank;
    logic [7:0] d;
    logic [11:0] a;
    logic [2:0] bm;
    logic [31:0] rd;
    logic start_pgm;
    logic start_erase;
    logic [`BFCC_DATA_W-1:0] status;
    nxt_s = s_ff;
    mem_we = 1'b0;
    mem_wa = s_ff.ptr;
    mem_wd = '1;
    setup = psel & ~penable;
    access = psel & penable & s_ff.pready;
    we_rise = pin.we_n & ~s_ff.prev_we & ~pin.ce_n;
    oe_fall = ~pin.oe_n & s_ff.prev_oe;
    bclk_rise = pin.burst_clk & ~s_ff.prev_bclk;
    d = pin.dq[7:0];
    a = pin.addr[11:0];
    bm = burst_mask(s_ff.ctrl[`BFCC_CTRL_LEN_LSB +: 2]);
    start_pgm = 1'b0;
    start_erase = 1'b0;
    rd = 32'h0000_0000;
    status = '0;
    busy = (s_ff.op == bfcc_pkg::OP_PGM) || (s_ff.op == bfcc_pkg::OP_ERASE) ||
           (s_ff.op == bfcc_pkg::OP_SPGM);
    busy_bank = bank_of((s_ff.op == bfcc_pkg::OP_ERASE) ? s_ff.ptr : s_ff.op_addr);
    raddr = s_ff.ctrl[`BFCC_CTRL_BURST_EN] ? s_ff.burst_addr : pin.addr;
    nxt_s.prev_we = pin.we_n;
    nxt_s.prev_oe = pin.oe_n;
    nxt_s.prev_bclk = pin.burst_clk;
    nxt_s.prev_addr = pin.addr;

    // register bus: answer one cycle after setup, write and clear before events set
    nxt_s.pready = setup;
    nxt_s.pslverr = 1'b0;
    if (setup)
    begin
      unique case (paddr)
        `BFCC_OFS_CTRL: rd = {28'h0, s_ff.ctrl};
        `BFCC_OFS_STATUS: rd = {25'h0, s_ff.pw_ok, s_ff.pmode, s_ff.sleep, s_ff.bypass,
                                s_ff.op == bfcc_pkg::OP_SUSP, busy};
        `BFCC_OFS_INT_STAT: rd = {29'h0, s_ff.int_stat};
        `BFCC_OFS_INT_MASK: rd = {29'h0, s_ff.int_mask};
        `BFCC_OFS_PROT_MODE: rd = {30'h0, s_ff.pmode};
        `BFCC_OFS_LOCK: rd = s_ff.lock;
        `BFCC_OFS_PW_LO, `BFCC_OFS_PW_HI: rd = 32'h0000_0000;
        default: nxt_s.pslverr = 1'b1;
      endcase
      nxt_s.prdata = rd;
    end
    if (access && pwrite && !s_ff.pslverr)
    begin
      unique case (paddr)
        `BFCC_OFS_CTRL: nxt_s.ctrl = pwdata[3:0];
        `BFCC_OFS_INT_STAT: nxt_s.int_stat = s_ff.int_stat & ~pwdata[2:0];
        `BFCC_OFS_INT_MASK: nxt_s.int_mask = pwdata[2:0];
        `BFCC_OFS_PROT_MODE:
          // choice is made once, from the persistent default
          if (s_ff.pmode == bfcc_pkg::PM_PERSIST && pwdata[1:0] != 2'h0 && pwdata[1:0] != 2'h3)
            nxt_s.pmode = bfcc_pkg::bfcc_pmode_t'(pwdata[1:0]);
          else
            nxt_s.int_stat[`BFCC_INT_REFUSED] = 1'b1;
        `BFCC_OFS_LOCK:
          if (s_ff.pmode == bfcc_pkg::PM_PASSWORD && !s_ff.pw_ok)
            nxt_s.int_stat[`BFCC_INT_REFUSED] = 1'b1;
          else
            nxt_s.lock = pwdata;
        `BFCC_OFS_PW_LO:
          if (s_ff.pmode == bfcc_pkg::PM_PASSWORD)
            nxt_s.pw_try_lo = pwdata;
          else
            nxt_s.pw[31:0] = pwdata;
        `BFCC_OFS_PW_HI:
          if (s_ff.pmode == bfcc_pkg::PM_PASSWORD)
            nxt_s.pw_ok = ({pwdata, s_ff.pw_try_lo} == s_ff.pw);
          else
            nxt_s.pw[63:32] = pwdata;
        default: ;
      endcase
    end

    // embedded engine
    unique case (s_ff.op)
      bfcc_pkg::OP_PGM, bfcc_pkg::OP_SPGM:
        if (s_ff.cnt == PGM_LAST)
        begin
          mem_we = 1'b1;
          mem_wa = s_ff.op_addr;
          mem_wd = s_ff.pgm_data & pgm_old;
          nxt_s.op = (s_ff.op == bfcc_pkg::OP_SPGM) ? bfcc_pkg::OP_SUSP : bfcc_pkg::OP_IDLE;
          nxt_s.int_stat[`BFCC_INT_DONE] = 1'b1;
        end
        else
          nxt_s.cnt = s_ff.cnt + 16'h0001;
      bfcc_pkg::OP_ERASE:
      begin
        mem_we = 1'b1;
        nxt_s.ptr = s_ff.ptr + AW'(1);
        if (s_ff.ptr == s_ff.erase_last)
        begin
          nxt_s.op = bfcc_pkg::OP_IDLE;
          nxt_s.int_stat[`BFCC_INT_DONE] = 1'b1;
        end
      end
      bfcc_pkg::OP_IDLE, bfcc_pkg::OP_SUSP: ;
    endcase

    // command decode, one step per host write cycle
    if (we_rise)
    begin
      if (d == `BFCC_D_RESET && s_ff.cmd != bfcc_pkg::C_PGM)
      begin
        nxt_s.cmd = bfcc_pkg::C_IDLE;
        nxt_s.secure = 1'b0;
      end
      else
      begin
        unique case (s_ff.cmd)
          bfcc_pkg::C_IDLE:
            if (s_ff.bypass && d == `BFCC_D_PGM)
              nxt_s.cmd = bfcc_pkg::C_PGM;
            else if (s_ff.bypass && d == `BFCC_D_BYP_EXIT1)
              nxt_s.cmd = bfcc_pkg::C_BX;
            else if (a == `BFCC_ADDR_UNLK1 && d == `BFCC_D_UNLK1)
              nxt_s.cmd = bfcc_pkg::C_U1;
            else if (d == `BFCC_D_SUSPEND && s_ff.op == bfcc_pkg::OP_ERASE)
              nxt_s.op = bfcc_pkg::OP_SUSP;
            else if (d == `BFCC_D_RESUME && s_ff.op == bfcc_pkg::OP_SUSP)
              nxt_s.op = bfcc_pkg::OP_ERASE;
          bfcc_pkg::C_U1:
            nxt_s.cmd = (a == `BFCC_ADDR_UNLK2 && d == `BFCC_D_UNLK2) ? bfcc_pkg::C_U2 : bfcc_pkg::C_IDLE;
          bfcc_pkg::C_U2:
          begin
            nxt_s.cmd = bfcc_pkg::C_IDLE;
            if (a == `BFCC_ADDR_UNLK1)
            begin
              if (d == `BFCC_D_PGM)
                nxt_s.cmd = bfcc_pkg::C_PGM;
              else if (d == `BFCC_D_ERASE)
                nxt_s.cmd = bfcc_pkg::C_E1;
              else if (d == `BFCC_D_BYPASS)
                nxt_s.bypass = 1'b1;
              else if (d == `BFCC_D_SECURE)
                nxt_s.secure = 1'b1;
            end
          end
          bfcc_pkg::C_PGM:
          begin
            nxt_s.cmd = bfcc_pkg::C_IDLE;
            start_pgm = 1'b1;
          end
          bfcc_pkg::C_E1:
            nxt_s.cmd = (a == `BFCC_ADDR_UNLK1 && d == `BFCC_D_UNLK1) ? bfcc_pkg::C_E2 : bfcc_pkg::C_IDLE;
          bfcc_pkg::C_E2:
            nxt_s.cmd = (a == `BFCC_ADDR_UNLK2 && d == `BFCC_D_UNLK2) ? bfcc_pkg::C_E3 : bfcc_pkg::C_IDLE;
          bfcc_pkg::C_E3:
          begin
            nxt_s.cmd = bfcc_pkg::C_IDLE;
            start_erase = (d == `BFCC_D_SECTOR);
          end
          bfcc_pkg::C_BX:
          begin
            nxt_s.cmd = bfcc_pkg::C_IDLE;
            if (d == `BFCC_D_BYP_EXIT2)
              nxt_s.bypass = 1'b0;
          end
        endcase
      end
    end

    // during suspend only sectors outside the erase may be programmed
    if (start_pgm && (s_ff.op == bfcc_pkg::OP_IDLE ||
        (s_ff.op == bfcc_pkg::OP_SUSP && sec_last(pin.addr) != s_ff.erase_last)))
    begin
      if (protected_at(pin.addr, pin.edge_lock_n, s_ff.lock))
        nxt_s.int_stat[`BFCC_INT_REFUSED] = 1'b1;
      else
      begin
        nxt_s.op = (s_ff.op == bfcc_pkg::OP_SUSP) ? bfcc_pkg::OP_SPGM : bfcc_pkg::OP_PGM;
        nxt_s.op_addr = pin.addr;
        nxt_s.pgm_data = pin.dq;
        nxt_s.cnt = 16'h0000;
      end
    end
    if (start_erase && s_ff.op == bfcc_pkg::OP_IDLE)
    begin
      if (protected_at(pin.addr, pin.edge_lock_n, s_ff.lock))
        nxt_s.int_stat[`BFCC_INT_REFUSED] = 1'b1;
      else
      begin
        nxt_s.op = bfcc_pkg::OP_ERASE;
        nxt_s.ptr = sec_base(pin.addr);
        nxt_s.erase_last = sec_last(pin.addr);
      end
    end

    if (!pin.hw_reset_n)
    begin
      nxt_s.op = bfcc_pkg::OP_IDLE;
      nxt_s.cmd = bfcc_pkg::C_IDLE;
      nxt_s.bypass = 1'b0;
      nxt_s.secure = 1'b0;
    end

    // burst address: load on strobe, step on each burst clock rise
    if (bclk_rise)
    begin
      if (!pin.address_load_strobe_n)
        nxt_s.burst_addr = pin.addr;
      else if (s_ff.ctrl[`BFCC_CTRL_LEN_LSB +: 2] == 2'h0 || !s_ff.ctrl[`BFCC_CTRL_WRAP])
        nxt_s.burst_addr = s_ff.burst_addr + AW'(1);
      else
        nxt_s.burst_addr = (s_ff.burst_addr & ~AW'(bm)) | ((s_ff.burst_addr + AW'(1)) & AW'(bm));
    end

    // status word: polling bit inverts data bit 7 while programming, toggle flips per read
    if (oe_fall && busy && bank_of(raddr) == busy_bank)
      nxt_s.toggle = ~s_ff.toggle;
    status[7] = (s_ff.op == bfcc_pkg::OP_ERASE) ? 1'b0 : ~s_ff.pgm_data[7];
    status[6] = s_ff.toggle;
    if (s_ff.secure)
      nxt_s.dq_o = mark_word(raddr[`BFCC_SECURE_AW-1:0]);
    else if (busy && bank_of(raddr) == busy_bank)
      nxt_s.dq_o = status;
    else
      nxt_s.dq_o = mem_q;
    nxt_s.dq_oe = ~pin.ce_n & ~pin.oe_n & pin.we_n;
    nxt_s.done = (nxt_s.op == bfcc_pkg::OP_IDLE) || (nxt_s.op == bfcc_pkg::OP_SUSP);

    // sleep needs an idle engine too, since writes keep the array busy anyway
    if (pin.addr != s_ff.prev_addr || busy)
    begin
      nxt_s.sleep_cnt = 16'h0000;
      nxt_s.sleep = 1'b0;
    end
    else if (s_ff.sleep_cnt != SLEEP_LAST)
      nxt_s.sleep_cnt = s_ff.sleep_cnt + 16'h0001;
    else if (!s_ff.sleep)
    begin
      nxt_s.sleep = 1'b1;
      nxt_s.int_stat[`BFCC_INT_SLEEP] = 1'b1;
    end
    nxt_s.irq = |(nxt_s.int_stat & nxt_s.int_mask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_ff <= '0;
      s_ff.prev_we <= 1'b1;
      s_ff.prev_oe <= 1'b1;
      s_ff.prev_bclk <= 1'b1;
      s_ff.prev_addr <= '1;
      s_ff.done <= 1'b1;
      s_ff.ctrl <= `BFCC_CTRL_RST;
      s_ff.int_mask <= `BFCC_INT_RST;
      s_ff.pmode <= bfcc_pkg::PM_PERSIST;
    end
    else
      s_ff <= nxt_s;
  end

  assign prdata = s_ff.prdata;
  assign pready = s_ff.pready;
  assign pslverr = s_ff.pslverr;
  assign dq_o = s_ff.dq_o;
  assign dq_oe = s_ff.dq_oe;
  assign done_indicator = s_ff.done;
  assign irq = s_ff.irq;
endmodule // bfcc_top

// *** shared/bfcc_cfg.svh ***
// Purpose: constants of the burst flash command control block
// Assumes: pclk at 200 MHz, APB with 32-bit data
// Notes: offsets are byte addresses on the APB slave
// Summary of operation
// - in bypass mode a word programs with two write cycles instead of four.
// - two banks; reads of the idle bank return array data while the other works.
// - hardware reset pin aborts any operation and returns to array read.
// - protection mode starts persistent until standard or password is chosen.
// - edge lock pin blocks program/erase of two outermost 8KB large-bank sectors.
// - completion shows on done indicator, polarity poll bit and toggling bit.
// - after program or erase the device reads array and takes new commands.
// - erase suspend allows reads and programs outside the erasing sector indefinitely.
// - stable address for a set interval puts the device in automatic sleep.
// - the last write cycle of a command latches the address, and for program the data, for the embedded engine.
// - password mode refuses protection changes until the password matches.
// - separate 256-byte secure sector holds factory marking data.
// - array holds 32-bit words, 1,048,576 locations.
// - sector erase clears only the chosen sector.
// - linear bursts of 2, 4 or 8 words, with or without wrap.
// - the protection password is 64 bits.
`ifndef BFCC_CFG_SVH
`define BFCC_CFG_SVH
`define BFCC_ADDR_W 20
`define BFCC_DATA_W 32
`define BFCC_CLK_MHZ 200
`define BFCC_PGM_NS 1000
`define BFCC_PGM_CYC ((`BFCC_PGM_NS * `BFCC_CLK_MHZ) / 1000)
`define BFCC_SLEEP_NS 300
`define BFCC_SLEEP_CYC ((`BFCC_SLEEP_NS * `BFCC_CLK_MHZ) / 1000)
`define BFCC_OFS_CTRL 8'h00
`define BFCC_OFS_STATUS 8'h04
`define BFCC_OFS_INT_STAT 8'h08
`define BFCC_OFS_INT_MASK 8'h0C
`define BFCC_OFS_PROT_MODE 8'h10
`define BFCC_OFS_LOCK 8'h14
`define BFCC_OFS_PW_LO 8'h18
`define BFCC_OFS_PW_HI 8'h1C
`define BFCC_CTRL_BURST_EN 0
`define BFCC_CTRL_LEN_LSB 1
`define BFCC_CTRL_WRAP 3
`define BFCC_CTRL_RST 4'h0
`define BFCC_INT_DONE 0
`define BFCC_INT_REFUSED 1
`define BFCC_INT_SLEEP 2
`define BFCC_INT_RST 3'h0
`define BFCC_SMALL_SEC_W 11
`define BFCC_BIG_SEC_W 14
`define BFCC_LOCK_GRP_LSB 15
`define BFCC_SECURE_AW 6
`define BFCC_ADDR_UNLK1 12'h555
`define BFCC_ADDR_UNLK2 12'h2AA
`define BFCC_D_UNLK1 8'hAA
`define BFCC_D_UNLK2 8'h55
`define BFCC_D_PGM 8'hA0
`define BFCC_D_ERASE 8'h80
`define BFCC_D_SECTOR 8'h30
`define BFCC_D_BYPASS 8'h20
`define BFCC_D_BYP_EXIT1 8'h90
`define BFCC_D_BYP_EXIT2 8'h00
`define BFCC_D_SUSPEND 8'hB0
`define BFCC_D_RESUME 8'h30
`define BFCC_D_RESET 8'hF0
`define BFCC_D_SECURE 8'h88
`endif

// *** shared/bfcc_pkg.sv ***
// Purpose: types of the burst flash command control block
// Assumes: constants come from bfcc_cfg.svh
// Notes: state of the top module is one packed struct
`include "bfcc_cfg.svh"
package bfcc_pkg;
  typedef enum logic [3:0] {C_IDLE, C_U1, C_U2, C_PGM, C_E1, C_E2, C_E3, C_BX} bfcc_cmd_t;
  typedef enum logic [2:0] {OP_IDLE, OP_PGM, OP_ERASE, OP_SUSP, OP_SPGM} bfcc_op_t;
  typedef enum logic [1:0] {PM_PERSIST, PM_STANDARD, PM_PASSWORD} bfcc_pmode_t;
  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic address_load_strobe_n;
    logic burst_clk;
    logic edge_lock_n;
    logic hw_reset_n;
    logic [`BFCC_ADDR_W-1:0] addr;
    logic [`BFCC_DATA_W-1:0] dq;
  } bfcc_pins_t;
  typedef struct packed {
    bfcc_cmd_t cmd;
    bfcc_op_t op;
    logic bypass;
    logic secure;
    logic [`BFCC_ADDR_W-1:0] op_addr;
    logic [`BFCC_DATA_W-1:0] pgm_data;
    logic [`BFCC_ADDR_W-1:0] ptr;
    logic [`BFCC_ADDR_W-1:0] erase_last;
    logic [15:0] cnt;
    logic toggle;
    logic prev_we;
    logic prev_oe;
    logic prev_bclk;
    logic [`BFCC_ADDR_W-1:0] prev_addr;
    logic [15:0] sleep_cnt;
    logic sleep;
    logic [`BFCC_ADDR_W-1:0] burst_addr;
    logic [3:0] ctrl;
    logic [2:0] int_stat;
    logic [2:0] int_mask;
    bfcc_pmode_t pmode;
    logic [31:0] lock;
    logic [63:0] pw;
    logic [31:0] pw_try_lo;
    logic pw_ok;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [`BFCC_DATA_W-1:0] dq_o;
    logic dq_oe;
    logic done;
    logic irq;
  } bfcc_state_t;
endpackage

// *** hw/bfcc_sync.sv ***
// Purpose: two-flop synchroniser for a bundle of pin levels
// Assumes: each bit is a level; multi-bit words are held stable by the host
// Notes: only the second stage is visible outside
`timescale 1ns/1ps
module bfcc_sync #(
  parameter int W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_ff <= '1;
      q_ff <= '1;
    end
    else
    begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule // bfcc_sync

// *** verification/bfcc_props.sv ***
// Purpose: port assertions for bfcc_top
// Assumes: one pclk domain, APB answer in the cycle after setup
// Notes: bound to the top module at the foot of this file
`timescale 1ns/1ps
`include "bfcc_cfg.svh"
module bfcc_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire bfcc_pkg::bfcc_pins_t pin_i,
  input wire logic [`BFCC_DATA_W-1:0] dq_o,
  input wire logic dq_oe,
  input wire logic done_indicator,
  input wire logic irq
);
  logic rd_req;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  assign rd_req = !pin_i.ce_n && !pin_i.oe_n && pin_i.we_n;
  setup_ready_a:
    assert property (psel && !penable |=> pready) else $error("setup not answered");
  ready_pulse_a:
    assert property (pready |=> !pready) else $error("ready held too long");
  err_with_ready_a:
    assert property (pslverr |-> pready) else $error("error without ready");
  unmapped_err_a:
    assert property (psel && !penable && paddr > 8'h1C |=> pslverr) else $error("unmapped not refused");
  mapped_ok_a:
    assert property (psel && !penable && paddr <= 8'h1C && paddr[1:0] == 2'h0 |=> !pslverr)
      else $error("mapped refused");
  irq_masked_a:
    assert property (psel && penable && pready && pwrite && paddr == 8'h0C && pwdata[2:0] == 3'h0
      |-> ##[1:2] !irq) else $error("irq stays with mask clear");
  pin_reset_idle_a:
    assert property (!pin_i.hw_reset_n [*6] |-> done_indicator) else $error("reset pin did not idle");
  drive_cause_a:
    assert property (dq_oe |-> $past(rd_req, 3)) else $error("drive without read");
  read_drive_a:
    assert property (rd_req [*5] |-> dq_oe) else $error("read not driven");
  reset_state_a:
    assert property ($rose(presetn) |-> done_indicator && !irq && !dq_oe && prdata == 32'h0)
      else $error("bad state after reset");
endmodule // bfcc_props
bind bfcc_top bfcc_props u_props (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pin_i(pin_i), .dq_o(dq_o), .dq_oe(dq_oe), .done_indicator(done_indicator), .irq(irq));

// *** verification/bfcc_host_model.sv ***
// Purpose: host processor side of the flash pins
// Assumes: pins change just after pclk rises
// Notes: burst strobe and clock stay idle, no burst traffic here
`timescale 1ns/1ps
`include "bfcc_cfg.svh"
module bfcc_host_model (
  input wire logic pclk,
  input wire logic [`BFCC_DATA_W-1:0] dq_o,
  input wire logic dq_oe,
  input wire logic edge_lock_n,
  input wire logic hw_reset_n,
  output bfcc_pkg::bfcc_pins_t pins
);
  initial
  begin
    pins = '1;
    pins.addr = '0;
  end
  always @(posedge pclk)
  begin
    pins.edge_lock_n <= edge_lock_n;
    pins.hw_reset_n <= hw_reset_n;
  end
  // strobe phases of four cycles beat the two-flop synchroniser
  task automatic wcyc(input logic [19:0] a, input logic [31:0] d);
    @(posedge pclk);
    pins.addr <= a;
    pins.dq <= d;
    pins.ce_n <= 1'b0;
    @(posedge pclk);
    pins.we_n <= 1'b0;
    repeat (4) @(posedge pclk);
    pins.we_n <= 1'b1;
    repeat (4) @(posedge pclk);
    pins.ce_n <= 1'b1;
    pins.dq <= ~d; // released bus must not look like the last word
  endtask
  task automatic rd(input logic [19:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    pins.addr <= a;
    pins.ce_n <= 1'b0;
    @(posedge pclk);
    pins.oe_n <= 1'b0;
    while (dq_oe !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    repeat (3) @(posedge pclk);
    d = dq_o;
    pins.oe_n <= 1'b1;
    pins.ce_n <= 1'b1;
    // let the drive enable fall before the next read looks at it
    repeat (4) @(posedge pclk);
  endtask
endmodule // bfcc_host_model

// *** verification/test_burst_flash_command_control.sv ***
// Purpose: self-checking bench for bfcc_top
// Assumes: host pins come from bfcc_host_model
// Notes: sectors are erased before any program is checked
`timescale 1ns/1ps
`include "bfcc_cfg.svh"
module test_burst_flash_command_control;
  typedef struct {
    logic [7:0] a;
    logic w;
    logic [31:0] d;
    logic [31:0] e;
    logic se;
  } bfcc_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  bfcc_pkg::bfcc_pins_t pins;
  logic [`BFCC_DATA_W-1:0] dq_o;
  logic dq_oe;
  logic done_indicator;
  logic irq;
  logic edge_lock_n = 1'b1;
  logic hw_reset_n = 1'b1;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [31:0] rv;
  logic [31:0] rv2;
  logic se;
  // burst enable stays clear here, or every array read would follow the burst pointer
  bfcc_row_t rows [18] = '{
    '{8'h00, 1'b1, 32'hE, 32'h0, 1'b0}, '{8'h00, 1'b0, 32'h0, 32'hE, 1'b0},
    '{8'h14, 1'b1, 32'h2, 32'h0, 1'b0}, '{8'h14, 1'b0, 32'h0, 32'h2, 1'b0},
    '{8'h18, 1'b1, 32'h1234_ABCD, 32'h0, 1'b0}, '{8'h18, 1'b0, 32'h0, 32'h0, 1'b0},
    '{8'h10, 1'b1, 32'h2, 32'h0, 1'b0}, '{8'h10, 1'b1, 32'h1, 32'h0, 1'b0},
    '{8'h10, 1'b0, 32'h0, 32'h2, 1'b0}, '{8'h14, 1'b1, 32'h0, 32'h0, 1'b0},
    '{8'h14, 1'b0, 32'h0, 32'h2, 1'b0}, '{8'h18, 1'b1, 32'h1234_ABCD, 32'h0, 1'b0},
    '{8'h1C, 1'b1, 32'h0, 32'h0, 1'b0}, '{8'h14, 1'b1, 32'h6, 32'h0, 1'b0},
    '{8'h14, 1'b0, 32'h0, 32'h6, 1'b0}, '{8'h20, 1'b0, 32'h0, 32'h0, 1'b1},
    '{8'h0C, 1'b1, 32'h2, 32'h0, 1'b0}, '{8'h08, 1'b1, 32'h7, 32'h0, 1'b0}};
  bfcc_top DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_i(pins),
    .dq_o(dq_o), .dq_oe(dq_oe), .done_indicator(done_indicator), .irq(irq));
  bfcc_host_model u_host (.pclk(pclk), .dq_o(dq_o), .dq_oe(dq_oe), .edge_lock_n(edge_lock_n),
    .hw_reset_n(hw_reset_n), .pins(pins));
  initial
  begin
    forever #2.5 pclk = ~pclk;
  end
  task automatic report_and_stop;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors++;
      report_and_stop();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
      errors++;
  endtask
  task automatic wait_done;
    int n;
    n = 0;
    repeat (4) @(posedge pclk);
    while (done_indicator !== 1'b1 && n < 5000)
    begin
      @(posedge pclk);
      n++;
    end
    chk("done_indicator", 32'h1, {31'h0, done_indicator});
  endtask
  task automatic unlock;
    u_host.wcyc(20'h00555, 32'(`BFCC_D_UNLK1));
    u_host.wcyc(20'h002AA, 32'(`BFCC_D_UNLK2));
  endtask
  task automatic pgm(input logic [19:0] a, input logic [31:0] d);
    unlock();
    u_host.wcyc(20'h00555, 32'(`BFCC_D_PGM));
    u_host.wcyc(a, d);
  endtask
  task automatic erase(input logic [19:0] a);
    unlock();
    u_host.wcyc(20'h00555, 32'(`BFCC_D_ERASE));
    unlock();
    u_host.wcyc(a, 32'(`BFCC_D_SECTOR));
  endtask
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    chk("reset outputs", 32'h1, {28'h0, pready, dq_oe, irq, done_indicator});
    apb(1'b0, 8'h10, 32'h0, rv, se);
    chk("prot_mode", 32'h0, rv);
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d, rv, se);
      chk("slverr", {31'h0, rows[i].se}, {31'h0, se});
      if (!rows[i].w && !rows[i].se)
        chk("register", rows[i].e, rv);
    end
    repeat (70) @(posedge pclk);
    apb(1'b0, 8'h04, 32'h0, rv, se);
    chk("sleep", 32'h1, {31'h0, rv[3]});
    erase(20'hFF000);
    wait_done();
    pgm(20'hFF010, 32'hA5A5_0F0F);
    chk("busy", 32'h0, {31'h0, done_indicator});
    u_host.rd(20'hFF010, rv);
    chk("poll bit", 32'h1, {31'h0, rv[7]});
    wait_done();
    u_host.rd(20'hFF010, rv);
    chk("programmed", 32'hA5A5_0F0F, rv);
    erase(20'h01000);
    u_host.rd(20'hFF010, rv);
    chk("other bank", 32'hA5A5_0F0F, rv);
    u_host.rd(20'h01000, rv);
    u_host.rd(20'h01000, rv2);
    chk("erase poll", 32'h0, {31'h0, rv[7]});
    chk("toggle", 32'h1, {31'h0, rv[6] ^ rv2[6]});
    u_host.wcyc(20'h01000, 32'(`BFCC_D_SUSPEND));
    wait_done();
    pgm(20'hFF020, 32'h3C3C_3C3C);
    wait_done();
    u_host.rd(20'hFF020, rv);
    chk("suspend pgm", 32'h3C3C_3C3C, rv);
    u_host.wcyc(20'h01000, 32'(`BFCC_D_RESUME));
    chk("resumed", 32'h0, {31'h0, done_indicator});
    wait_done();
    u_host.rd(20'h01000, rv);
    chk("erased", 32'hFFFF_FFFF, rv);
    u_host.rd(20'hFF010, rv);
    chk("kept", 32'hA5A5_0F0F, rv);
    unlock();
    u_host.wcyc(20'h00555, 32'(`BFCC_D_BYPASS));
    u_host.wcyc(20'h00555, 32'(`BFCC_D_PGM));
    u_host.wcyc(20'h01020, 32'h0000_FFFF);
    wait_done();
    u_host.rd(20'h01020, rv);
    chk("bypass pgm", 32'h0000_FFFF, rv);
    apb(1'b0, 8'h04, 32'h0, rv, se);
    chk("bypass flag", 32'h1, {31'h0, rv[2]});
    u_host.wcyc(20'h00555, 32'(`BFCC_D_BYP_EXIT1));
    u_host.wcyc(20'h00555, 32'(`BFCC_D_BYP_EXIT2));
    unlock();
    u_host.wcyc(20'h00555, 32'(`BFCC_D_SECURE));
    u_host.rd(20'hFF010, rv);
    chk("secure word", 32'h1, {31'h0, rv != 32'hA5A5_0F0F});
    u_host.wcyc(20'h00555, 32'(`BFCC_D_RESET));
    edge_lock_n <= 1'b0;
    pgm(20'h00010, 32'h0);
    chk("locked idle", 32'h1, {31'h0, done_indicator});
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, 8'h08, 32'h2, rv, se);
    repeat (3) @(posedge pclk);
    chk("irq clear", 32'h0, {31'h0, irq});
    apb(1'b1, 8'h0C, 32'h0, rv, se);
    pgm(20'h00010, 32'h0);
    chk("masked", 32'h0, {31'h0, irq});
    apb(1'b0, 8'h08, 32'h0, rv, se);
    chk("refused flag", 32'h1, {31'h0, rv[1]});
    edge_lock_n <= 1'b1;
    pgm(20'h01030, 32'h0);
    hw_reset_n <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("abort", 32'h1, {31'h0, done_indicator});
    hw_reset_n <= 1'b1;
    repeat (4) @(posedge pclk);
    u_host.rd(20'hFF010, rv);
    chk("array read", 32'hA5A5_0F0F, rv);
    report_and_stop();
  end
endmodule // test_burst_flash_command_control
